// file: rtl/pafm_pkg.sv
`default_nettype none
package pafm_pkg;
    // Register byte addresses on APB
    localparam logic [7:0] PAFM_DIR_ADDR    = 8'h00;
    localparam logic [7:0] PAFM_LATCH_ADDR  = 8'h04;
    localparam logic [7:0] PAFM_PIN_ADDR    = 8'h08;
    localparam logic [7:0] PAFM_PULLUP_ADDR = 8'h0c;
    localparam logic [7:0] PAFM_ODR_ADDR    = 8'h10;
    localparam logic [7:0] PAFM_FUNC_ADDR   = 8'h14;
    localparam logic [7:0] PAFM_SER_ADDR    = 8'h18;
    // Serial control field positions in the serial register
    localparam int PAFM_SER_CLKSRC_POS = 0;
    localparam int PAFM_SER_CLKOUT_POS = 1;
    localparam int PAFM_SER_SYNC_POS   = 2;
    localparam int PAFM_SER_RXON_POS   = 3;
    localparam int PAFM_SER_TXON_POS   = 4;
    localparam int PAFM_SER_WIDTH    = 5;
    // Reset values
    localparam logic [3:0] PAFM_PORT_RST = 4'h0;
    localparam logic [3:0] PAFM_AE_RST   = 4'h0;
    localparam logic [4:0] PAFM_SER_RST  = 5'h00;
    // Operating modes
    localparam logic [2:0] PAFM_MODE_LO = 3'h4;
    localparam logic [2:0] PAFM_MODE_HI = 3'h6;
    localparam logic [2:0] PAFM_MODE_SC = 3'h7;
    // Pin function encoding
    typedef enum logic [1:0] {
        PAFM_FN_GPIO,
        PAFM_FN_ADDR,
        PAFM_FN_SER_IN,
        PAFM_FN_SER_OUT
    } pafm_fn_t;
endpackage : pafm_pkg
`default_nettype wire

// file: rtl/pafm_sync.sv
`default_nettype none
module pafm_sync
    import pafm_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    // Two-stage capture; the first stage feeds only the second
    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stage1   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule : pafm_sync
`default_nettype wire

// file: rtl/pafm_top.sv
`default_nettype none
module pafm_top
    import pafm_pkg::*;
#(
    parameter bit HAS_ADDR_BUS = 1'b1
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        standby_hw,
    input  wire logic [2:0]  op_mode,
    input  wire logic [3:0]  upper_addr_lines,
    input  wire logic        ser_clk_out,
    input  wire logic        ser_tx_data,
    output var  logic        ser_clk_in,
    output var  logic        ser_rx_data,
    input  wire logic [3:0]  port_pins_in,
    output var  logic [3:0]  port_pins_out,
    output var  logic [3:0]  port_pins_oe_b,
    output var  logic [3:0]  pullup_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr
);
    localparam logic [3:0] PIN_MASK = HAS_ADDR_BUS ? 4'hf : 4'he;

    logic [3:0]  port_direction_bits, port_output_latch, pullup_ctrl_bits, open_drain_bits;
    logic [3:0]  addr_enable_field;
    logic [4:0]  serial_ctrl;
    logic [3:0]  next_dir, next_latch, next_pullup, next_odr, next_ae;
    logic [4:0]  next_ser;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr;
    logic [3:0]  pin_sync, pin_read;
    logic [3:0]  next_pins_out, next_oe_b, next_pullup_en;
    logic        next_clk_in, next_rx;
    logic        addr_mode, serial_clk_source, clock_pin_out_en, sync_async_select;
    logic        rx_on_bit, tx_on_bit;
    logic [3:0]  addr_sel;
    pafm_fn_t    fn [4];
    logic [3:0]  fn_data;
    logic        apb_setup;

    // Pin input synchroniser
    pafm_sync #(.WIDTH(4)) u_sync (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .async_in (port_pins_in),
        .sync_out (pin_sync)
    );

    // Serial control decode
    always_comb begin
        serial_clk_source = serial_ctrl[PAFM_SER_CLKSRC_POS];
        clock_pin_out_en  = serial_ctrl[PAFM_SER_CLKOUT_POS];
        sync_async_select = serial_ctrl[PAFM_SER_SYNC_POS];
        rx_on_bit         = serial_ctrl[PAFM_SER_RXON_POS];
        tx_on_bit         = serial_ctrl[PAFM_SER_TXON_POS];
        addr_mode = HAS_ADDR_BUS && (op_mode >= PAFM_MODE_LO) && (op_mode <= PAFM_MODE_HI);
    end

    // Address enable decode per pin
    always_comb begin
        addr_sel[3] = addr_mode && (addr_enable_field[3:2] == 2'h3);
        addr_sel[2] = addr_mode && ((addr_enable_field == 4'hb)
                                    || (addr_enable_field[3:2] == 2'h3));
        addr_sel[1] = addr_mode && ((addr_enable_field[3:1] == 3'h5)
                                    || (addr_enable_field[3:2] == 2'h3));
        addr_sel[0] = addr_mode && addr_enable_field[3]
                      && (addr_enable_field != 4'h8);
    end

    // Function selection per pin
    always_comb begin
        fn_data = upper_addr_lines;
        fn[0] = addr_sel[0] ? PAFM_FN_ADDR : PAFM_FN_GPIO;
        if (addr_sel[1]) begin
            fn[1] = PAFM_FN_ADDR;
        end else if (tx_on_bit) begin
            fn[1] = PAFM_FN_SER_OUT;
            fn_data[1] = ser_tx_data;
        end else begin
            fn[1] = PAFM_FN_GPIO;
        end
        if (addr_sel[2]) begin
            fn[2] = PAFM_FN_ADDR;
        end else if (rx_on_bit) begin
            fn[2] = PAFM_FN_SER_IN;
        end else begin
            fn[2] = PAFM_FN_GPIO;
        end
        if (addr_sel[3]) begin
            fn[3] = PAFM_FN_ADDR;
        end else if (serial_clk_source) begin
            fn[3] = PAFM_FN_SER_IN;
        end else if (sync_async_select || clock_pin_out_en) begin
            fn[3] = PAFM_FN_SER_OUT;
            fn_data[3] = ser_clk_out;
        end else begin
            fn[3] = PAFM_FN_GPIO;
        end
    end

    // Pin drivers, pull-ups and read value per pin
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_pins_out[i]  = 1'b0;
            next_oe_b[i]      = 1'b1;
            next_pullup_en[i] = 1'b0;
            pin_read[i] = port_direction_bits[i] ? port_output_latch[i] : pin_sync[i];
            if (PIN_MASK[i]) begin
                unique case (fn[i])
                    PAFM_FN_ADDR: begin
                        next_pins_out[i] = fn_data[i];
                        next_oe_b[i]     = 1'b0;
                    end
                    PAFM_FN_SER_OUT: begin
                        next_pins_out[i] = fn_data[i];
                        next_oe_b[i]     = open_drain_bits[i] & fn_data[i];
                    end
                    PAFM_FN_SER_IN: begin
                        next_pullup_en[i] = !port_direction_bits[i]
                                            && pullup_ctrl_bits[i] && !standby_hw;
                    end
                    PAFM_FN_GPIO: begin
                        if (port_direction_bits[i]) begin
                            next_pins_out[i] = port_output_latch[i];
                            next_oe_b[i] = open_drain_bits[i] & port_output_latch[i];
                        end else begin
                            next_pullup_en[i] = pullup_ctrl_bits[i] && !standby_hw;
                        end
                    end
                endcase
            end else begin
                pin_read[i] = 1'b0;
            end
        end
        next_clk_in = pin_sync[3] & (fn[3] == PAFM_FN_SER_IN);
        next_rx     = (fn[2] == PAFM_FN_SER_IN) ? pin_sync[2] : 1'b1;
    end

    // APB register access, zero wait states
    always_comb begin
        apb_setup    = psel && !penable;
        next_dir     = port_direction_bits;
        next_latch   = port_output_latch;
        next_pullup  = pullup_ctrl_bits;
        next_odr     = open_drain_bits;
        next_ae      = addr_enable_field;
        next_ser     = serial_ctrl;
        next_prdata  = prdata;
        next_pready  = apb_setup;
        next_pslverr = 1'b0;
        if (apb_setup) begin
            next_prdata = '0;
            unique case (paddr)
                PAFM_DIR_ADDR:    next_prdata[3:0] = port_direction_bits;
                PAFM_LATCH_ADDR:  next_prdata[3:0] = port_output_latch;
                PAFM_PIN_ADDR:    next_prdata[3:0] = pin_read;
                PAFM_PULLUP_ADDR: next_prdata[3:0] = pullup_ctrl_bits;
                PAFM_ODR_ADDR:    next_prdata[3:0] = open_drain_bits;
                PAFM_FUNC_ADDR:   next_prdata[3:0] = addr_enable_field;
                PAFM_SER_ADDR:    next_prdata[4:0] = serial_ctrl;
                default:          next_pslverr = 1'b1;
            endcase
        end
        // Writes commit at the edge that completes the access phase
        if (psel && penable && pready && pwrite) begin
            unique case (paddr)
                PAFM_DIR_ADDR:    next_dir    = pwdata[3:0] & PIN_MASK;
                PAFM_LATCH_ADDR:  next_latch  = pwdata[3:0] & PIN_MASK;
                PAFM_PULLUP_ADDR: next_pullup = pwdata[3:0] & PIN_MASK;
                PAFM_ODR_ADDR:    next_odr    = pwdata[3:0] & PIN_MASK;
                PAFM_FUNC_ADDR:   next_ae     = pwdata[3:0];
                PAFM_SER_ADDR:    next_ser    = pwdata[PAFM_SER_WIDTH-1:0];
                default:          next_ser    = serial_ctrl;
            endcase
        end
    end

    // Register stage: reset forces pins to input with pull-ups off
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            port_direction_bits <= PAFM_PORT_RST;
            port_output_latch   <= PAFM_PORT_RST;
            pullup_ctrl_bits    <= PAFM_PORT_RST;
            open_drain_bits     <= PAFM_PORT_RST;
            addr_enable_field   <= PAFM_AE_RST;
            serial_ctrl         <= PAFM_SER_RST;
            prdata              <= '0;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
            port_pins_out       <= '0;
            port_pins_oe_b      <= '1;
            pullup_en           <= '0;
            ser_clk_in          <= 1'b0;
            ser_rx_data         <= 1'b1;
        end else if (clk_en) begin
            port_direction_bits <= next_dir;
            port_output_latch   <= next_latch;
            pullup_ctrl_bits    <= next_pullup;
            open_drain_bits     <= next_odr;
            addr_enable_field   <= next_ae;
            serial_ctrl         <= next_ser;
            prdata              <= next_prdata;
            pready              <= next_pready;
            pslverr             <= next_pslverr;
            port_pins_out       <= next_pins_out;
            port_pins_oe_b      <= next_oe_b;
            pullup_en           <= next_pullup_en;
            ser_clk_in          <= next_clk_in;
            ser_rx_data         <= next_rx;
        end
    end

    // Checks
    mode7_no_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && op_mode == PAFM_MODE_SC |-> addr_sel == 4'h0)
        else $error("address selected in mode 7");
    pin3_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && addr_mode && addr_enable_field[3:2] == 2'h3 |=> !port_pins_oe_b[3])
        else $error("pin 3 not driving address");
    pin2_rx_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && !addr_sel[2] && rx_on_bit |=> port_pins_oe_b[2])
        else $error("pin 2 driven while receiving");
    pin1_tx_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && !addr_sel[1] && tx_on_bit && !open_drain_bits[1]
        |=> !port_pins_oe_b[1] && port_pins_out[1] == $past(ser_tx_data))
        else $error("pin 1 not transmitting");
    pin0_gpio_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && addr_enable_field == 4'h8 |-> !addr_sel[0])
        else $error("pin 0 address on 1000");
    no_pin0_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !PIN_MASK[0] |-> port_pins_oe_b[0] && !pullup_en[0])
        else $error("absent pin 0 active");
    pullup_rule_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        pullup_en[0] |-> $past(!port_direction_bits[0] && pullup_ctrl_bits[0]))
        else $error("pull-up on without cause");
    out_no_pull_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (pullup_en & ~port_pins_oe_b) == 4'h0)
        else $error("pull-up on driven pin");
    od_low_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !port_pins_oe_b[3] && $past(open_drain_bits[3] && fn[3] != PAFM_FN_ADDR)
        |-> !port_pins_out[3])
        else $error("open drain drove high");
    read_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        clk_en && apb_setup && !pwrite && paddr == PAFM_PIN_ADDR
        |=> pready && prdata[3:0] == $past((port_direction_bits & port_output_latch)
                                           | (~port_direction_bits & pin_sync & PIN_MASK)))
        else $error("read not answered");
    cov_addr_c: cover property (@(posedge clk_sys) addr_sel == 4'hf);
    cov_sck_in_c: cover property (@(posedge clk_sys) fn[3] == PAFM_FN_SER_IN);
    cov_pull_c: cover property (@(posedge clk_sys) pullup_en != 4'h0);
endmodule : pafm_top
`default_nettype wire

// file: testbench/pafm_pins.sv
`default_nettype none
module pafm_pins (
    input  wire logic       clk_sys,
    input  wire logic [3:0] port_pins_out,
    input  wire logic [3:0] port_pins_oe_b,
    input  wire logic [3:0] pullup_en,
    input  wire logic [3:0] ext_drive,
    input  wire logic [3:0] ext_en,
    output var  logic [3:0] port_pins_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] float_lvl = 4'h5;
    // A floating pin with no pull-up shows a level that changes every cycle
    always_ff @(posedge clk_sys) begin
        float_lvl <= ~port_pins_in;
    end
    // Wire level: device drive first, then the far side, then the pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!port_pins_oe_b[i]) begin
                port_pins_in[i] = port_pins_out[i];
            end else if (ext_en[i]) begin
                port_pins_in[i] = ext_drive[i];
            end else if (pullup_en[i]) begin
                port_pins_in[i] = 1'b1;
            end else begin
                port_pins_in[i] = float_lvl[i];
            end
        end
    end
endmodule : pafm_pins
`default_nettype wire

// file: testbench/pafm_top_tb.sv
`default_nettype none
module pafm_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pafm_pkg::*;
    logic        clk_sys, rst_b, standby_hw, psel, penable, pwrite;
    logic        ser_clk_out, ser_tx_data, ser_clk_in, ser_rx_data, pready, pslverr, err;
    logic [2:0]  op_mode;
    logic [3:0]  upper_addr_lines, ext_drive, ext_en, amask;
    logic [3:0]  port_pins_in, port_pins_out, port_pins_oe_b, pullup_en, oe_b_nab;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  ser_val [5] = '{5'h01, 5'h03, 5'h02, 5'h04, 5'h18};
    logic [5:0]  ser_exp [5] = '{6'h3f, 6'h3f, 6'h1d, 6'h1d, 6'h34};
    int          n_errors, samples_checked;

    pafm_top pafm_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
        .standby_hw(standby_hw), .op_mode(op_mode), .upper_addr_lines(upper_addr_lines),
        .ser_clk_out(ser_clk_out), .ser_tx_data(ser_tx_data), .ser_clk_in(ser_clk_in),
        .ser_rx_data(ser_rx_data), .port_pins_in(port_pins_in),
        .port_pins_out(port_pins_out), .port_pins_oe_b(port_pins_oe_b),
        .pullup_en(pullup_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // Variant without the address bus, fed the same stimulus
    pafm_top #(.HAS_ADDR_BUS(1'b0)) pafm_top_nab_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .clk_en(1'b1), .standby_hw(standby_hw), .op_mode(op_mode),
        .upper_addr_lines(upper_addr_lines), .ser_clk_out(ser_clk_out),
        .ser_tx_data(ser_tx_data), .ser_clk_in(), .ser_rx_data(),
        .port_pins_in(port_pins_in), .port_pins_out(), .port_pins_oe_b(oe_b_nab),
        .pullup_en(), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr());
    pafm_pins pafm_pins_i (.clk_sys(clk_sys), .port_pins_out(port_pins_out),
        .port_pins_oe_b(port_pins_oe_b), .pullup_en(pullup_en), .ext_drive(ext_drive),
        .ext_en(ext_en), .port_pins_in(port_pins_in));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is sampled high, giving up after 20 access cycles
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            print_verdict();
        end
    endtask : apb

    task automatic settle(input int c);
        repeat (c) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    // Pins that carry address lines for a mode and enable field
    function automatic logic [3:0] addr_mask(input int m, input logic [3:0] ae);
        if (m == 7) return 4'h0;
        return {ae[3:2] == 2'b11, ae == 4'hb || ae[3:2] == 2'b11,
                ae[3:1] == 3'b101 || ae[3:2] == 2'b11, ae[3] && ae != 4'h8};
    endfunction : addr_mask

    initial begin
        {rst_b, standby_hw, psel, penable, pwrite, ser_clk_out, ser_tx_data} = 7'h00;
        {op_mode, upper_addr_lines, ext_drive, ext_en, paddr, pwdata} = '0;
        n_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        settle(1);
        chk(32'(port_pins_oe_b), 32'hf);
        chk(32'(pullup_en), 32'h0);
        chk(32'(ser_rx_data), 32'h1);
        for (int a = 0; a <= 'h18; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            if (a != 8) chk(rd, 32'h0);
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("Test reset and unmapped done");
        op_mode <= 3'h7;
        apb(1'b1, PAFM_DIR_ADDR, 32'hf);
        apb(1'b1, PAFM_LATCH_ADDR, 32'h5);
        settle(2);
        chk(32'({port_pins_oe_b, port_pins_out}), 32'h05);
        apb(1'b1, PAFM_ODR_ADDR, 32'hf);
        settle(2);
        chk(32'({port_pins_oe_b, port_pins_out & ~port_pins_oe_b}), 32'h50);
        apb(1'b1, PAFM_ODR_ADDR, 32'h0);
        apb(1'b1, PAFM_DIR_ADDR, 32'h3);
        apb(1'b1, PAFM_LATCH_ADDR, 32'h6);
        apb(1'b1, PAFM_PULLUP_ADDR, 32'hf);
        ext_en <= 4'hc;
        ext_drive <= 4'h8;
        settle(5);
        apb(1'b0, PAFM_PIN_ADDR, 32'h0);
        chk(rd, 32'ha);
        chk(32'(pullup_en), 32'hc);
        @(posedge clk_sys);
        standby_hw <= 1'b1;
        settle(2);
        chk(32'(pullup_en), 32'h0);
        @(posedge clk_sys);
        standby_hw <= 1'b0;
        $display("Test port output, input and pull-up done");
        apb(1'b1, PAFM_DIR_ADDR, 32'h0);
        ext_en <= 4'h0;
        for (int m = 4; m <= 7; m++) begin
            for (int ae = 0; ae < 16; ae++) begin
                @(posedge clk_sys);
                op_mode <= 3'(m);
                upper_addr_lines <= 4'(ae) ^ 4'h5;
                apb(1'b1, PAFM_FUNC_ADDR, 32'(ae));
                settle(2);
                amask = addr_mask(m, 4'(ae));
                chk(32'(port_pins_oe_b), {28'h0, ~amask});
                chk(32'(port_pins_out & amask), 32'(upper_addr_lines & amask));
                chk(32'(pullup_en), {28'h0, ~amask});
                chk(32'(oe_b_nab), 32'hf);
            end
        end
        $display("Test address functions done");
        apb(1'b1, PAFM_FUNC_ADDR, 32'h0);
        apb(1'b1, PAFM_PULLUP_ADDR, 32'h0);
        ext_en <= 4'hf;
        ext_drive <= 4'h8;
        ser_clk_out <= 1'b1;
        ser_tx_data <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, PAFM_SER_ADDR, 32'(ser_val[i]));
            settle(5);
            chk(32'({port_pins_oe_b, ser_clk_in, ser_rx_data}), 32'(ser_exp[i]));
            chk(32'(port_pins_out | port_pins_oe_b), 32'hf);
            @(posedge clk_sys);
            {ser_clk_out, ser_tx_data} <= 2'b00;
            settle(2);
            chk(32'(port_pins_out), 32'h0);
            @(posedge clk_sys);
            {ser_clk_out, ser_tx_data} <= 2'b11;
        end
        $display("Test serial functions done");
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict();
    end
endmodule : pafm_top_tb
`default_nettype wire
